// ===== hw/ssf_pkg.sv
// Shared constants and state type for the synchronous serial frame engine
package ssf_pkg;

  // Frame format select
  localparam logic       FMT_SPI        = 1'b0;
  localparam logic       FMT_HD         = 1'b1;

  // Data size field holds word length minus one (3..15)
  localparam logic [3:0] SIZE_MAX       = 4'hF;

  // Half-duplex frame layout, counted in serial clock edges
  localparam logic [5:0] HD_CTRL_END    = 6'h10;
  localparam logic [5:0] HD_REPLY_RISE  = 6'h13;
  localparam logic [5:0] HD_EXTRA_EDGES = 6'h12;
  localparam logic [5:0] EDGE_FIRST     = 6'h01;
  localparam logic [5:0] EDGE_ONE       = 6'h01;

  // Waits in half serial clock periods
  localparam logic [1:0] HALF_ONE       = 2'h1;
  localparam logic [1:0] HALF_TWO       = 2'h2;

  // Values after reset
  localparam logic       RST_SCLK       = 1'b0;
  localparam logic       RST_FSS        = 1'b1;
  localparam logic       RST_TXD        = 1'b0;
  localparam logic       RST_OE_N       = 1'b1;
  localparam logic       RST_CTL_OE_N   = 1'b1;
  localparam logic [5:0] RST_EDGES      = 6'h00;
  localparam logic [15:0] RST_WORD      = 16'h0000;
  localparam logic [6:0] RST_PRE        = 7'h00;
  localparam logic [7:0] RST_RATE       = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_SHIFT,
    ST_TAIL,
    ST_GAP,
    ST_SLAVE
  } ssf_state_t;

endpackage : ssf_pkg

// ===== hw/ssf_clkdiv.sv
// Serial clock divider giving one enable pulse per half serial clock period
`timescale 1ns/1ps
module ssf_clkdiv (
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  input  wire logic       run_i,
  input  wire logic [7:0] prescale_i,
  input  wire logic [7:0] rate_i,
  output logic            half_tick_o
);
  import ssf_pkg::*;

  typedef struct packed {
    logic [6:0] pre;
    logic [7:0] rate;
    logic       tick;
  } ssf_div_t;

  ssf_div_t   r_ff;
  ssf_div_t   nxt_r;
  logic [6:0] half_pre;

  always_comb begin
    nxt_r      = r_ff;
    nxt_r.tick = 1'b0;
    // Odd or zero prescale is rounded down, never below two
    half_pre   = (prescale_i[7:1] == 7'h00) ? 7'h01 : prescale_i[7:1];
    if (!run_i) begin
      nxt_r.pre  = RST_PRE;
      nxt_r.rate = RST_RATE;
    end else if (r_ff.pre == half_pre - 7'h01) begin
      nxt_r.pre = RST_PRE;
      if (r_ff.rate == rate_i) begin
        nxt_r.rate = RST_RATE;
        nxt_r.tick = 1'b1;
      end else begin
        nxt_r.rate = r_ff.rate + 8'h01;
      end
    end else begin
      nxt_r.pre = r_ff.pre + 7'h01;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      r_ff <= '{pre: RST_PRE, rate: RST_RATE, tick: 1'b0};
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign half_tick_o = r_ff.tick;

endmodule : ssf_clkdiv

// ===== hw/ssf_port.sv
// Synchronous serial port frame engine: four SPI modes and half-duplex control-word format
`timescale 1ns/1ps
module ssf_port (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        port_enable_i,
  input  wire logic        master_mode_i,
  input  wire logic        frame_format_i,
  input  wire logic        clock_polarity_i,
  input  wire logic        clock_phase_i,
  input  wire logic [3:0]  data_size_i,
  input  wire logic [7:0]  prescale_divisor_i,
  input  wire logic [7:0]  serial_clock_rate_i,
  input  wire logic        tx_valid_i,
  input  wire logic [15:0] tx_data_i,
  input  wire logic        serial_clock_in_i,
  input  wire logic        frame_select_in_i,
  input  wire logic        serial_rx_line_i,
  output logic             tx_pop_o,
  output logic             rx_valid_o,
  output logic [15:0]      rx_data_o,
  output logic             busy_o,
  output logic             serial_clock_out_o,
  output logic             frame_select_out_o,
  output logic             serial_tx_line_o,
  output logic             tx_pad_enable_n_o,
  output logic             clock_pad_enable_n_o
);
  import ssf_pkg::*;

  typedef struct packed {
    ssf_state_t  state;
    logic        sclk;
    logic        fss;
    logic        txd;
    logic        oe_n;
    logic        ctl_oe_n;
    logic        run;
    logic        tx_pop;
    logic        rx_valid;
    logic        busy;
    logic        sck_prev;
    logic        fsi_prev;
    logic [1:0]  half;
    logic [5:0]  ecnt;
    logic [15:0] tx_sh;
    logic [15:0] rx_sh;
    logic [15:0] rx_data;
  } ssf_regs_t;

  localparam ssf_regs_t REGS_RST = '{
    state: ST_IDLE, sclk: RST_SCLK, fss: RST_FSS, txd: RST_TXD, oe_n: RST_OE_N,
    ctl_oe_n: RST_CTL_OE_N, run: 1'b0, tx_pop: 1'b0, rx_valid: 1'b0, busy: 1'b0,
    sck_prev: 1'b0, fsi_prev: 1'b1, half: 2'h0, ecnt: RST_EDGES,
    tx_sh: RST_WORD, rx_sh: RST_WORD, rx_data: RST_WORD};

  ssf_regs_t   r_ff;
  ssf_regs_t   nxt_r;
  logic        half_tick;
  logic [5:0]  k;
  logic [5:0]  last_edge;
  logic        spi_sample;
  logic        spi_evt;
  logic        avail;
  logic        go;
  logic        idle_clk;
  logic [15:0] rx_next;
  logic [15:0] tx_left;

  ssf_clkdiv u_div (
    .core_clk_i  (core_clk_i),
    .rst_i       (rst_i),
    .run_i       (nxt_r.run),
    .prescale_i  (prescale_divisor_i),
    .rate_i      (serial_clock_rate_i),
    .half_tick_o (half_tick)
  );

  always_comb begin
    nxt_r          = r_ff;
    nxt_r.tx_pop   = 1'b0;
    nxt_r.rx_valid = 1'b0;
    nxt_r.sck_prev = serial_clock_in_i;
    nxt_r.fsi_prev = frame_select_in_i;
    go             = 1'b0;
    nxt_r.ctl_oe_n = ~master_mode_i;
    k              = r_ff.ecnt + EDGE_ONE;
    last_edge      = {1'b0, data_size_i, 1'b0} + 6'h02;
    spi_sample     = clock_phase_i ? ~k[0] : k[0];
    rx_next        = {r_ff.rx_sh[14:0], serial_rx_line_i};
    tx_left        = tx_data_i << (SIZE_MAX - data_size_i);
    avail          = port_enable_i && tx_valid_i;
    idle_clk       = (frame_format_i == FMT_HD) ? 1'b0 : clock_polarity_i;
    spi_evt        = (r_ff.state == ST_SHIFT && half_tick && frame_format_i == FMT_SPI)
                  || (r_ff.state == ST_SLAVE && serial_clock_in_i != r_ff.sck_prev);

    if (spi_evt) begin
      nxt_r.ecnt = k;
      if (r_ff.state == ST_SHIFT) begin
        nxt_r.sclk = ~r_ff.sclk;
      end
      if (spi_sample) begin
        nxt_r.rx_sh = rx_next;
        if (k == (clock_phase_i ? last_edge : last_edge - EDGE_ONE)) begin
          nxt_r.rx_valid = 1'b1;
          nxt_r.rx_data  = rx_next;
        end
      end else if (k == EDGE_FIRST) begin
        // phase high data with first edge
        nxt_r.txd = r_ff.tx_sh[15];
      end else if (k != last_edge) begin
        nxt_r.tx_sh = r_ff.tx_sh << 1;
        nxt_r.txd   = r_ff.tx_sh[14];
      end
    end

    unique case (r_ff.state)
      ST_IDLE: begin
        nxt_r.sclk = idle_clk;
        nxt_r.fss  = 1'b1;
        nxt_r.txd  = 1'b0;
        nxt_r.oe_n = 1'b1;
        nxt_r.run  = 1'b0;
        if (avail && master_mode_i) begin
          go = 1'b1;
        end else if (port_enable_i && !master_mode_i && frame_format_i == FMT_SPI
                     && !frame_select_in_i && r_ff.fsi_prev) begin
          nxt_r.state  = ST_SLAVE;
          nxt_r.oe_n   = 1'b0;
          nxt_r.ecnt   = RST_EDGES;
          nxt_r.rx_sh  = RST_WORD;
          nxt_r.tx_sh  = avail ? tx_left : RST_WORD;
          nxt_r.tx_pop = avail;
          // Slave with phase low shows data as select falls
          nxt_r.txd    = (avail && !clock_phase_i) ? tx_left[15] : 1'b0;
        end
      end
      ST_SETUP: begin
        // master data half period after select
        if (half_tick) begin
          nxt_r.txd   = r_ff.tx_sh[15];
          nxt_r.state = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (half_tick && frame_format_i == FMT_SPI) begin
          if (k == last_edge) begin
            // phase high chains words with select low
            if (clock_phase_i && avail) begin
              go = 1'b1;
            end else begin
              nxt_r.state = ST_TAIL;
              nxt_r.half  = clock_phase_i ? HALF_TWO : HALF_ONE;
            end
          end
        end else if (half_tick) begin
          nxt_r.ecnt = k;
          nxt_r.sclk = ~r_ff.sclk;
          if (k[0]) begin
            if (k >= HD_REPLY_RISE) begin
              nxt_r.rx_sh = rx_next;
            end
          end else begin
            // command bits, then wait clock, then reply
            if (k < HD_CTRL_END) begin
              nxt_r.tx_sh = r_ff.tx_sh << 1;
              nxt_r.txd   = r_ff.tx_sh[14];
            end else if (k == HD_CTRL_END) begin
              nxt_r.txd = 1'b0;
            end
            if (k == last_edge + HD_EXTRA_EDGES) begin
              nxt_r.rx_data = r_ff.rx_sh;
              if (avail) begin
                nxt_r.rx_valid = 1'b1;
                go             = 1'b1;
              end else begin
                nxt_r.state = ST_TAIL;
                nxt_r.half  = HALF_ONE;
              end
            end
          end
        end
      end
      ST_TAIL: begin
        if (half_tick) begin
          if (r_ff.half == HALF_ONE) begin
            // select returns high half a period after the last edge, one period with phase high
            nxt_r.fss  = 1'b1;
            nxt_r.oe_n = 1'b1;
            nxt_r.txd  = 1'b0;
            nxt_r.sclk = idle_clk;
            nxt_r.rx_valid = (frame_format_i == FMT_HD);
            // phase low pulses select between words
            if (frame_format_i == FMT_SPI && !clock_phase_i && avail) begin
              nxt_r.state = ST_GAP;
              nxt_r.half  = HALF_TWO;
            end else begin
              nxt_r.state = ST_IDLE;
              nxt_r.run   = 1'b0;
            end
          end else begin
            nxt_r.half = r_ff.half - HALF_ONE;
          end
        end
      end
      ST_GAP: begin
        if (half_tick) begin
          if (r_ff.half == HALF_ONE) begin
            if (avail) begin
              go = 1'b1;
            end else begin
              nxt_r.state = ST_IDLE;
              nxt_r.run   = 1'b0;
            end
          end else begin
            nxt_r.half = r_ff.half - HALF_ONE;
          end
        end
      end
      ST_SLAVE: begin
        if (frame_select_in_i) begin
          nxt_r.oe_n  = 1'b1;
          nxt_r.txd   = 1'b0;
          nxt_r.state = ST_IDLE;
        end else if (spi_evt && k == last_edge) begin
          // Word done with select still low: reload for the next one
          nxt_r.ecnt   = RST_EDGES;
          nxt_r.rx_sh  = RST_WORD;
          nxt_r.tx_sh  = avail ? tx_left : RST_WORD;
          nxt_r.tx_pop = avail;
          if (!clock_phase_i) begin
            nxt_r.txd = avail ? tx_left[15] : 1'b0;
          end
        end
      end
    endcase

    if (go) begin
      // command MSB out as select falls
      nxt_r.fss    = 1'b0;
      nxt_r.oe_n   = 1'b0;
      nxt_r.run    = 1'b1;
      nxt_r.tx_pop = 1'b1;
      nxt_r.rx_sh  = RST_WORD;
      nxt_r.ecnt   = RST_EDGES;
      if (frame_format_i == FMT_HD) begin
        nxt_r.tx_sh = {tx_data_i[7:0], 8'h00};
        nxt_r.txd   = tx_data_i[7];
        nxt_r.state = ST_SHIFT;
      end else begin
        // phase low edges start half period later
        nxt_r.tx_sh = tx_left;
        nxt_r.state = clock_phase_i ? ST_SHIFT : ST_SETUP;
      end
    end

    if (!port_enable_i) begin
      nxt_r.state = ST_IDLE;
      nxt_r.run   = 1'b0;
      nxt_r.fss   = 1'b1;
      nxt_r.oe_n  = 1'b1;
      nxt_r.txd   = 1'b0;
      nxt_r.sclk  = idle_clk;
    end
    nxt_r.busy = (nxt_r.state != ST_IDLE);
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      r_ff <= REGS_RST;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign tx_pop_o             = r_ff.tx_pop;
  assign rx_valid_o           = r_ff.rx_valid;
  assign rx_data_o            = r_ff.rx_data;
  assign busy_o               = r_ff.busy;
  assign serial_clock_out_o   = r_ff.sclk;
  assign frame_select_out_o   = r_ff.fss;
  assign serial_tx_line_o     = r_ff.txd;
  assign tx_pad_enable_n_o    = r_ff.oe_n;
  assign clock_pad_enable_n_o = r_ff.ctl_oe_n;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  start_cond_a: assert property (
    $fell(frame_select_out_o) |-> $past(port_enable_i) && $past(tx_valid_i)
      && !tx_pad_enable_n_o && tx_pop_o)
    else $error("frame started without enable or data");
  clk_pad_a: assert property (
    !$past(rst_i) |-> clock_pad_enable_n_o == !$past(master_mode_i))
    else $error("clock pad enable does not follow role");
  idle_spi_a: assert property (
    (!busy_o && !$past(rst_i) && !$past(frame_format_i) && $past(clock_polarity_i))
      |-> serial_clock_out_o && frame_select_out_o && !serial_tx_line_o
          && tx_pad_enable_n_o)
    else $error("wrong idle levels with polarity high");
  idle_hd_a: assert property (
    (!busy_o && !$past(rst_i) && $past(frame_format_i))
      |-> !serial_clock_out_o && frame_select_out_o && !serial_tx_line_o)
    else $error("wrong idle levels in half-duplex format");
  hd_select_a: assert property (
    (r_ff.state == ST_SHIFT && frame_format_i == FMT_HD)
      |-> !frame_select_out_o && !tx_pad_enable_n_o)
    else $error("select high inside half-duplex frame");
  slave_oe_a: assert property (
    (r_ff.state == ST_SLAVE) |-> !tx_pad_enable_n_o && frame_select_out_o)
    else $error("slave transmit pad not driven");
  hd_deliver_a: assert property (
    ($rose(frame_select_out_o) && $past(frame_format_i) && $past(port_enable_i))
      |-> rx_valid_o)
    else $error("half-duplex reply not delivered at select rise");
  word_width_a: assert property (
    rx_valid_o && $stable(data_size_i)
      |-> (rx_data_o >> ({1'b0, data_size_i} + 5'h01)) == 16'h0000)
    else $error("received word wider than programmed size");
  disable_idle_a: assert property (
    !port_enable_i |=> !busy_o && frame_select_out_o && tx_pad_enable_n_o)
    else $error("port active while disabled");
  gap_high_a: assert property (
    (r_ff.state == ST_GAP) |-> frame_select_out_o && tx_pad_enable_n_o)
    else $error("select low in phase-low word gap");
  spi_master_c: cover property ($fell(frame_select_out_o) && !frame_format_i ##[1:300] rx_valid_o);
  hd_frame_c: cover property (
    (r_ff.state == ST_SHIFT && frame_format_i == FMT_HD) ##[1:1000] rx_valid_o);
  slave_word_c: cover property ((r_ff.state == ST_SLAVE) && rx_valid_o);
  chain_c: cover property (rx_valid_o && r_ff.state == ST_SHIFT && clock_phase_i);
endmodule : ssf_port

// ===== verif/ssf_far_dev.sv
// Far-side device model: SPI slave or half-duplex responder
`timescale 1ns/1ps
module ssf_far_dev (
  input  wire logic        clk_i,
  input  wire logic        hd_i,
  input  wire logic        pol_i,
  input  wire logic        pha_i,
  input  wire logic [3:0]  size_i,
  input  wire logic [15:0] reply_i,
  input  wire logic        sclk_i,
  input  wire logic        fss_n_i,
  input  wire logic        mosi_i,
  output logic             miso_o,
  output logic [15:0]      got_o
);
  logic        sq    = 1'b0;
  logic        fq    = 1'b1;
  logic        fresh = 1'b0;
  logic [15:0] sr    = 16'h0000;
  logic [4:0]  cnt   = 5'h00;
  logic [4:0]  rise  = 5'h00;
  initial miso_o = 1'b1;
  initial got_o = 16'h0000;
  // Runs on the falling core edge so the port always samples settled levels
  always @(negedge clk_i) begin
    if (fss_n_i) begin
      // released line never shows the stale bit
      if (!fq) miso_o = ~miso_o;
    end else if (fq) begin
      sr = reply_i;
      fresh = 1'b1;
      cnt = 5'h00;
      rise = 5'h00;
      got_o = 16'h0000;
      // phase low: slave bit at select fall
      if (!pha_i && !hd_i) miso_o = reply_i[size_i];
    end else if (sclk_i != sq) begin
      if (sclk_i) rise = rise + 5'h01;
      if (hd_i) begin
        // command on rising edges, reply after one wait clock
        if (sclk_i && rise <= 5'h08) got_o = {got_o[14:0], mosi_i};
        if (!sclk_i && rise == 5'h0A + {1'b0, size_i}) begin
          rise = 5'h00;
          sr = reply_i;
        end else if (!sclk_i && rise >= 5'h09) begin
          miso_o = sr[size_i];
          sr = sr << 1;
        end
      end else if (sclk_i == !(pol_i ^ pha_i)) begin
        got_o = {got_o[14:0], mosi_i};
        cnt = cnt + 5'h01;
        if (cnt == {1'b0, size_i} + 5'h01) begin
          cnt = 5'h00;
          fresh = 1'b1;
        end
      end else begin
        // phase high presents the first bit on the first edge
        if (fresh && pha_i) sr = reply_i;
        else sr = sr << 1;
        fresh = 1'b0;
        miso_o = sr[size_i];
      end
    end
    sq = sclk_i;
    fq = fss_n_i;
  end
endmodule : ssf_far_dev

// ===== verif/test_ssf_port.sv
// Self-checking bench for the serial frame engine
`timescale 1ns/1ps
module test_ssf_port;
  import ssf_pkg::*;
  localparam int H = 2;
  logic        clk = 1'b0, rst = 1'b1, en = 1'b1, mst = 1'b1, fmt = FMT_SPI;
  logic        pol = 1'b0, pha = 1'b0, txv = 1'b0, sci = 1'b0, fsi = 1'b1, smosi = 1'b0;
  logic [3:0]  sz = 4'h7;
  logic [15:0] txd = 16'h0000, reply = 16'h0000;
  logic        pop, rxv, busy, sco, fso, txl, oen, coen, miso, rxl;
  logic [15:0] rxd, got;
  logic [15:0] rxw [2];
  int          fails = 0;
  int          samples_checked = 0;
  int          k0, k1, kl, kr, krx, edges, rises, rxn;
  assign rxl = mst ? miso : smosi;
  ssf_port u_dut (
    .core_clk_i          (clk),
    .rst_i               (rst),
    .port_enable_i       (en),
    .master_mode_i       (mst),
    .frame_format_i      (fmt),
    .clock_polarity_i    (pol),
    .clock_phase_i       (pha),
    .data_size_i         (sz),
    .prescale_divisor_i  (8'h02),
    .serial_clock_rate_i (8'h01),
    .tx_valid_i          (txv),
    .tx_data_i           (txd),
    .serial_clock_in_i   (sci),
    .frame_select_in_i   (fsi),
    .serial_rx_line_i    (rxl),
    .tx_pop_o            (pop),
    .rx_valid_o          (rxv),
    .rx_data_o           (rxd),
    .busy_o              (busy),
    .serial_clock_out_o  (sco),
    .frame_select_out_o  (fso),
    .serial_tx_line_o    (txl),
    .tx_pad_enable_n_o   (oen),
    .clock_pad_enable_n_o(coen)
  );
  ssf_far_dev u_far (
    .clk_i  (clk),
    .hd_i   (fmt),
    .pol_i  (pol),
    .pha_i  (pha),
    .size_i (sz),
    .reply_i(reply),
    .sclk_i (sco),
    .fss_n_i(fso),
    .mosi_i (txl),
    .miso_o (miso),
    .got_o  (got)
  );
  initial forever #12.5 clk = ~clk;
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic final_report();
    if (fails == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  // Config is only touched while idle; three edges let idle levels settle
  task automatic cfg(input logic m, f, po, ph, input logic [3:0] s);
    @(negedge clk);
    {mst, fmt, pol, pha, sz} = {m, f, po, ph, s};
    repeat (3) @(negedge clk);
  endtask : cfg
  // Feeds n words and records select, clock and receive timing in core cycles
  task automatic run(input int n, input logic [15:0] w0, w1);
    int k, p, q;
    logic sq, fq;
    {k, p, q, edges, rises, rxn, k0} = '0;
    rxw = '{16'h0, 16'h0};
    @(negedge clk);
    {sq, fq} = {sco, fso};
    txd = w0;
    txv = 1'b1;
    while (q < 4 && k < 3000) begin
      @(negedge clk);
      k++;
      q = (p == n && busy === 1'b0) ? q + 1 : 0;
      if (pop === 1'b1) begin
        p++;
        txv = (p < n);
        txd = w1;
      end
      if (rxv === 1'b1 && rxn < 2) begin
        rxw[rxn] = rxd;
        krx = k;
        rxn++;
      end
      if (sco !== sq) begin
        edges++;
        if (edges == 1) k1 = k;
        kl = k;
      end
      if (fq === 1'b1 && fso === 1'b0 && k0 == 0) k0 = k;
      if (fq === 1'b0 && fso === 1'b1) begin
        rises++;
        kr = k;
      end
      {sq, fq} = {sco, fso};
    end
    chk("frame end", 16'h1, {15'h0, q == 4});
  endtask : run
  task automatic t_idle();
    cfg(1'b1, FMT_SPI, 1'b1, 1'b0, 4'h7);
    chk("idle pins", 16'h1A, {11'h0, sco, fso, txl, oen, coen});
    cfg(1'b1, FMT_HD, 1'b1, 1'b0, 4'h7);
    chk("hd idle pins", 16'h0A, {11'h0, sco, fso, txl, oen, coen});
    cfg(1'b0, FMT_SPI, 1'b0, 1'b0, 4'h7);
    chk("slave idle pins", 16'h0B, {11'h0, sco, fso, txl, oen, coen});
  endtask : t_idle
  task automatic t_spi();
    logic [15:0] m, w;
    logic [3:0] s;
    for (int i = 0; i < 4; i++) begin
      s = (i == 0) ? 4'h3 : (i == 3) ? 4'hF : 4'h7;
      m = 16'hFFFF >> (4'hF - s);
      w = 16'hC3A5 & m;
      reply = (16'h5A3C ^ 16'(i)) & m;
      cfg(1'b1, FMT_SPI, i[1], i[0], s);
      run(1, w, w);
      chk("mosi word", w, got);
      chk("miso word", reply, rxw[0]);
      chk("edges", 16'(2 * (s + 1)), 16'(edges));
      chk("lead", i[0] ? 16'(H) : 16'(2 * H), 16'(k1 - k0));
      chk("tail", i[0] ? 16'(2 * H) : 16'(H), 16'(kr - kl));
      chk("idle clock", {15'h0, pol}, {15'h0, sco});
    end
  endtask : t_spi
  task automatic t_b2b();
    reply = 16'h0096;
    for (int i = 0; i < 2; i++) begin
      cfg(1'b1, FMT_SPI, 1'b0, i[0], 4'h7);
      run(2, 16'h0081, 16'h007E);
      chk("select rises", i[0] ? 16'h1 : 16'h2, 16'(rises));
      chk("second word", reply, rxw[1]);
      chk("mosi words", i[0] ? 16'h817E : 16'h007E, got);
    end
  endtask : t_b2b
  task automatic t_hd();
    reply = 16'h00E7;
    for (int n = 1; n < 3; n++) begin
      cfg(1'b1, FMT_HD, 1'b0, 1'b0, 4'h7);
      run(n, 16'h00C3, 16'h0035);
      chk("hd edges", 16'(34 * n), 16'(edges));
      chk("hd reply", reply, rxw[n - 1]);
      chk("hd select", 16'h1, 16'(rises));
      chk("hd command", n == 1 ? 16'h00C3 : 16'hC335, got);
      if (n == 1) begin
        chk("hd tail", 16'(H), 16'(kr - kl));
        chk("hd delivery", 16'(kr), 16'(krx));
      end
    end
  endtask : t_hd
  task automatic t_off();
    int bad;
    bad = 0;
    cfg(1'b1, FMT_SPI, 1'b0, 1'b0, 4'h7);
    en = 1'b0;
    txv = 1'b1;
    repeat (20) begin
      @(negedge clk);
      if (busy !== 1'b0 || fso !== 1'b1 || pop !== 1'b0) bad++;
    end
    txv = 1'b0;
    en = 1'b1;
    chk("disabled activity", 16'h0, 16'(bad));
  endtask : t_off
  // Bench plays the external master, phase low, polarity low
  task automatic t_slave();
    logic [15:0] sv;
    logic [7:0] b;
    sv = 16'h0;
    b = 8'h6D;
    cfg(1'b0, FMT_SPI, 1'b0, 1'b0, 4'h7);
    txd = 16'h00B4;
    txv = 1'b1;
    fsi = 1'b0;
    repeat (3) @(negedge clk);
    txv = 1'b0;
    chk("slave pads", 16'h1, {14'h0, oen, coen});
    for (int i = 7; i >= 0; i--) begin
      smosi = b[i];
      repeat (4) @(negedge clk);
      sv = {sv[14:0], txl};
      sci = 1'b1;
      repeat (4) @(negedge clk);
      sci = 1'b0;
    end
    repeat (4) @(negedge clk);
    chk("slave sent", 16'h00B4, sv);
    chk("slave got", 16'h006D, rxd);
    fsi = 1'b1;
    repeat (3) @(negedge clk);
    chk("slave release", 16'h1, {15'h0, oen});
  endtask : t_slave
  initial begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    t_idle();
    t_spi();
    t_b2b();
    t_hd();
    t_off();
    t_slave();
    final_report();
  end
  // Whole run needs under a thousand cycles; this limit only cuts a hang
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    final_report();
  end
endmodule : test_ssf_port
